//--- rtl/xmem_ctrl.sv
// External parallel memory interface: registers, pin takeover, access sequencer
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "xmem_map.svh"

module xmem_ctrl
    import xmem_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [7:0]  port_a_out,
    input  wire logic [7:0]  port_a_dir,
    input  wire logic [7:0]  port_c_out,
    input  wire logic [7:0]  port_c_dir,
    input  wire logic [2:0]  port_g_out,
    input  wire logic [2:0]  port_g_dir,
    input  wire logic [7:0]  mux_addr_data_lines_in,
    output logic [7:0]       mux_addr_data_lines_out,
    output logic [7:0]       mux_addr_data_lines_oe,
    output logic [7:0]       high_address_lines_out,
    output logic [7:0]       high_address_lines_oe,
    output logic             addr_latch_strobe,
    output logic             write_strobe_n,
    output logic             read_strobe_n,
    output logic [2:0]       strobe_pins_oe,
    output logic             ext_mem_active
);

    ctrl_a_t     ctrl_a_reg, ctrl_a_next;
    ctrl_b_t     ctrl_b_reg, ctrl_b_next;
    bus_state_t  state_reg, state_next;
    logic [15:0] addr_reg, addr_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        is_write_reg, is_write_next;
    logic [1:0]  wait_cnt_reg, wait_cnt_next;
    logic [1:0]  acc_code_reg, acc_code_next;
    logic        hold_due_reg, hold_due_next;
    logic [7:0]  keep_reg, keep_next;
    logic [7:0]  ad_sync1_reg, ad_sync2_reg;
    logic        ack_reg, ack_next;
    logic        wr_take, busy;
    logic [2:0]  cap_pipe_reg, cap_pipe_next;
    logic [31:0] rd_reg, rd_next;
    logic [1:0]  wait_code;
    logic        pending_reg, pending_next;
    pin_drive_t  ad_drive, hi_drive;
    logic [7:0]  hi_owned;
    logic [7:0]  lo_bus_val;
    logic        lo_bus_en;
    logic        ale, wr_n, rd_n;

    xmem_sector u_sector (
        .ctrl_a    (ctrl_a_reg),
        .addr      (addr_reg),
        .wait_code (wait_code)
    );

    // Pins from outside pass two flops before anything reads them
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ad_sync1_reg <= `BYTE_ZERO;
            ad_sync2_reg <= `BYTE_ZERO;
        end else begin
            ad_sync1_reg <= mux_addr_data_lines_in;
            ad_sync2_reg <= ad_sync1_reg;
        end
    end

    // Register bus and access sequencer
    always_comb begin
        ctrl_a_next   = ctrl_a_reg;
        ctrl_b_next   = ctrl_b_reg;
        state_next    = state_reg;
        addr_next     = addr_reg;
        wdata_next    = wdata_reg;
        rdata_next    = rdata_reg;
        is_write_next = is_write_reg;
        wait_cnt_next = wait_cnt_reg;
        acc_code_next = acc_code_reg;
        hold_due_next = hold_due_reg;
        pending_next  = pending_reg;
        ack_next      = (avs_read || avs_write) && !ack_reg;
        rd_next       = rd_reg;
        // Writes land only at the edge where waitrequest is low
        wr_take       = avs_write && ack_reg;
        busy          = pending_reg || (cap_pipe_reg != 3'h0);
        cap_pipe_next = {cap_pipe_reg[1:0], 1'b0};
        if (avs_read || avs_write) begin
            unique case (avs_address)
                `CTRL_A_OFFSET: begin
                    rd_next = {24'h000000, ctrl_a_reg};
                    if (wr_take) ctrl_a_next = ctrl_a_t'(avs_writedata[7:0]);
                end
                `CTRL_B_OFFSET: begin
                    rd_next = {24'h000000, ctrl_b_reg};
                    if (wr_take) begin
                        ctrl_b_next = ctrl_b_t'(avs_writedata[7:0] & `CTRL_B_WR_MASK);
                    end
                end
                `STATUS_OFFSET: rd_next = {29'h0, state_reg};
                `ACCESS_OFFSET: begin
                    rd_next = {31'h0, busy};
                    if (wr_take && !busy && ctrl_a_reg.ext_mem_enable) begin
                        pending_next  = avs_writedata[`ACC_READ_BIT]
                                      | avs_writedata[`ACC_WRITE_BIT];
                        is_write_next = avs_writedata[`ACC_WRITE_BIT];
                    end
                end
                `ADDR_LO_OFFSET: begin
                    rd_next = {24'h000000, addr_reg[7:0]};
                    if (wr_take && !pending_reg) addr_next[7:0] = avs_writedata[7:0];
                end
                `ADDR_HI_OFFSET: begin
                    rd_next = {24'h000000, addr_reg[15:8]};
                    if (wr_take && !pending_reg) addr_next[15:8] = avs_writedata[7:0];
                end
                `WDATA_OFFSET: begin
                    rd_next = {24'h000000, wdata_reg};
                    if (wr_take && !pending_reg) wdata_next = avs_writedata[7:0];
                end
                `RDATA_OFFSET: rd_next = {24'h000000, rdata_reg};
                default: rd_next = `WORD_ZERO;
            endcase
        end

        unique case (state_reg)
            ST_IDLE: begin
                if (pending_reg) begin
                    acc_code_next = wait_code;
                    state_next    = ST_ADDR;
                end
            end
            ST_ADDR: begin
                state_next = ST_STROBE;
                wait_cnt_next = (acc_code_reg == `WAIT_CODE_ONE) ? 2'h1 :
                                (acc_code_reg == `WAIT_ZERO) ? 2'h0 : 2'h2;
                hold_due_next = (acc_code_reg == `WAIT_CODE_THREE);
            end
            ST_STROBE: begin
                if (wait_cnt_reg != `WAIT_ZERO) begin
                    wait_cnt_next = wait_cnt_reg - 2'h1;
                end else begin
                    if (!is_write_reg) cap_pipe_next[0] = 1'b1;
                    state_next = hold_due_reg ? ST_HOLD : ST_IDLE;
                    if (!hold_due_reg) pending_next = 1'b0;
                end
            end
            ST_HOLD: begin
                state_next   = ST_IDLE;
                pending_next = 1'b0;
            end
            default: state_next = ST_IDLE;
        endcase
        // Pin register plus two sync flops show the last strobe cycle three cycles late
        if (cap_pipe_reg[`CAPTURE_TAP]) rdata_next = ad_sync2_reg;
        // Dropping the enable aborts an access so the pins return cleanly
        if (!ctrl_a_next.ext_mem_enable && state_reg != ST_IDLE) begin
            state_next   = ST_IDLE;
            pending_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_a_reg   <= ctrl_a_t'(`CTRL_A_RESET);
            ctrl_b_reg   <= ctrl_b_t'(`CTRL_B_RESET);
            state_reg    <= ST_IDLE;
            addr_reg     <= 16'h0000;
            wdata_reg    <= `BYTE_ZERO;
            rdata_reg    <= `BYTE_ZERO;
            is_write_reg <= 1'b0;
            wait_cnt_reg <= `WAIT_ZERO;
            acc_code_reg <= `WAIT_ZERO;
            hold_due_reg <= 1'b0;
            pending_reg  <= 1'b0;
            cap_pipe_reg <= 3'h0;
            ack_reg      <= 1'b0;
            rd_reg       <= `WORD_ZERO;
        end else begin
            ctrl_a_reg   <= ctrl_a_next;
            ctrl_b_reg   <= ctrl_b_next;
            state_reg    <= state_next;
            addr_reg     <= addr_next;
            wdata_reg    <= wdata_next;
            rdata_reg    <= rdata_next;
            is_write_reg <= is_write_next;
            wait_cnt_reg <= wait_cnt_next;
            acc_code_reg <= acc_code_next;
            hold_due_reg <= hold_due_next;
            pending_reg  <= pending_next;
            cap_pipe_reg <= cap_pipe_next;
            ack_reg      <= ack_next;
            rd_reg       <= rd_next;
        end
    end

    // Low bus: address in the latch phase, write data during the strobe
    always_comb begin
        lo_bus_val = `BYTE_ZERO;
        lo_bus_en  = 1'b0;
        ale  = 1'b0;
        wr_n = 1'b1;
        rd_n = 1'b1;
        unique case (state_reg)
            ST_ADDR: begin
                lo_bus_val = addr_reg[7:0];
                lo_bus_en  = 1'b1;
                ale        = 1'b1;
            end
            ST_STROBE: begin
                lo_bus_val = wdata_reg;
                lo_bus_en  = is_write_reg;
                wr_n       = !is_write_reg;
                rd_n       = is_write_reg;
            end
            default: ;
        endcase
    end

    // Keeper tracks whatever is driven, interface or port, whether or not the keeper is enabled
    always_comb begin
        // Per line, so an undriven port bit never leaks into the held value
        keep_next = (ad_drive.out_en & ad_drive.out_val) | (~ad_drive.out_en & keep_reg);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) keep_reg <= `BYTE_ZERO;
        else       keep_reg <= keep_next;
    end

    // Pin takeover; the high mask frees port C from the top down
    generate
        for (genvar i = 0; i < 8; i++) begin : g_hi
            assign hi_owned[i] = (ctrl_b_reg.high_addr_mask == `MASK_NONE_FREE)
                               || (ctrl_b_reg.high_addr_mask != `MASK_ALL_FREE
                                   && (i < 8 - ctrl_b_reg.high_addr_mask));
        end
    endgenerate

    always_comb begin
        if (ctrl_a_reg.ext_mem_enable) begin
            ad_drive.out_val = lo_bus_val;
            ad_drive.out_en  = lo_bus_en ? `BYTE_ONES : `BYTE_ZERO;
            for (int j = 0; j < 8; j++) begin
                hi_drive.out_val[j] = hi_owned[j] ? addr_reg[8 + j] : port_c_out[j];
                hi_drive.out_en[j]  = hi_owned[j] ? 1'b1 : port_c_dir[j];
            end
        end else begin
            ad_drive.out_val = port_a_out;
            ad_drive.out_en  = port_a_dir;
            hi_drive.out_val = port_c_out;
            hi_drive.out_en  = port_c_dir;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mux_addr_data_lines_out <= `BYTE_ZERO;
            mux_addr_data_lines_oe  <= `BYTE_ZERO;
            high_address_lines_out  <= `BYTE_ZERO;
            high_address_lines_oe   <= `BYTE_ZERO;
            addr_latch_strobe       <= 1'b0;
            write_strobe_n          <= 1'b1;
            read_strobe_n           <= 1'b1;
            strobe_pins_oe          <= 3'h0;
        end else begin
            // Keeper drives only where the interface or port does not, never fighting the interface
            for (int k = 0; k < 8; k++) begin
                mux_addr_data_lines_out[k] <= ad_drive.out_en[k] ? ad_drive.out_val[k]
                                                                 : keep_reg[k];
                mux_addr_data_lines_oe[k]  <= ad_drive.out_en[k]
                                              | ctrl_b_reg.bus_keeper_enable;
            end
            high_address_lines_out  <= hi_drive.out_val;
            high_address_lines_oe   <= hi_drive.out_en;
            addr_latch_strobe <= ctrl_a_reg.ext_mem_enable ? ale : port_g_out[2];
            write_strobe_n    <= ctrl_a_reg.ext_mem_enable ? wr_n : port_g_out[0];
            read_strobe_n     <= ctrl_a_reg.ext_mem_enable ? rd_n : port_g_out[1];
            strobe_pins_oe    <= ctrl_a_reg.ext_mem_enable ? 3'h7 : port_g_dir;
        end
    end

    assign avs_readdata    = rd_reg;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign ext_mem_active  = ctrl_a_reg.ext_mem_enable;

endmodule // xmem_ctrl

`default_nettype wire

//--- rtl/xmem_map.svh
// Register offsets, field positions and constants of the external memory interface
`ifndef XMEM_MAP_SVH
`define XMEM_MAP_SVH

`define CTRL_A_OFFSET      8'h74
`define CTRL_B_OFFSET      8'h75
`define STATUS_OFFSET      8'h76
`define ACCESS_OFFSET      8'h77
`define ADDR_LO_OFFSET     8'h78
`define ADDR_HI_OFFSET     8'h79
`define WDATA_OFFSET       8'h7a
`define RDATA_OFFSET       8'h7b
`define CTRL_A_RESET       8'h00
`define CTRL_B_RESET       8'h00
`define CTRL_B_WR_MASK     8'h87
`define EXT_ENABLE_BIT     7
`define KEEPER_ENABLE_BIT  7
`define EXT_SPACE_BASE     16'h2200
`define WAIT_CODE_ONE      2'h1
`define WAIT_CODE_TWO      2'h2
`define WAIT_CODE_THREE    2'h3
`define WAIT_ZERO          2'h0
`define MASK_ALL_FREE      3'h7
`define MASK_NONE_FREE     3'h0
`define CAPTURE_TAP        2
`define BYTE_ZERO          8'h00
`define BYTE_ONES          8'hff
`define WORD_ZERO          32'h0000_0000
`define ACC_READ_BIT       0
`define ACC_WRITE_BIT      1

`endif

//--- rtl/xmem_pkg.sv
// Types shared by the external memory interface design files
package xmem_pkg;

    typedef struct packed {
        logic       ext_mem_enable;
        logic [2:0] sector_limit_select;
        logic [1:0] upper_wait_select;
        logic [1:0] lower_wait_select;
    } ctrl_a_t;

    typedef struct packed {
        logic       bus_keeper_enable;
        logic [3:0] reserved;
        logic [2:0] high_addr_mask;
    } ctrl_b_t;

    typedef struct packed {
        logic [7:0] out_val;
        logic [7:0] out_en;
    } pin_drive_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_STROBE,
        ST_WAIT,
        ST_HOLD
    } bus_state_t;

endpackage : xmem_pkg

//--- rtl/xmem_sector.sv
// Sector boundary decode and wait-state selection for one external access
`timescale 1ns/1ns
`default_nettype none
`include "xmem_map.svh"

module xmem_sector
    import xmem_pkg::*;
(
    input  wire ctrl_a_t     ctrl_a,
    input  wire logic [15:0] addr,
    output logic [1:0]       wait_code
);

    logic [15:0] boundary;
    logic        upper;

    always_comb begin
        // Codes 000 and 001 put the boundary at the base: the whole space is upper
        boundary = `EXT_SPACE_BASE;
        if (ctrl_a.sector_limit_select[2:1] != 2'h0) begin
            boundary = {ctrl_a.sector_limit_select, 13'h0000};
        end
        upper = (addr >= boundary);
        wait_code = upper ? ctrl_a.upper_wait_select
                          : ctrl_a.lower_wait_select;
    end

endmodule // xmem_sector

`default_nettype wire

//--- tb/xmem_ctrl_checker.sv
// Concurrent checks on the external memory interface ports
`timescale 1ns/1ns
`default_nettype none
module xmem_ctrl_checker
    import xmem_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [7:0]  port_a_dir,
    input wire logic [7:0]  port_c_dir,
    input wire logic [2:0]  port_g_dir,
    input wire logic [7:0]  mux_addr_data_lines_out,
    input wire logic [7:0]  mux_addr_data_lines_oe,
    input wire logic [7:0]  high_address_lines_out,
    input wire logic [7:0]  high_address_lines_oe,
    input wire logic        addr_latch_strobe,
    input wire logic        write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic [2:0]  strobe_pins_oe,
    input wire logic        ext_mem_active
);
    logic [7:0]  ca_reg, ca_next, keep;
    logic [3:0]  cb_reg, cb_next;
    logic [15:0] ad_reg, ad_next;
    logic [2:0]  cnt_reg, cnt_next, len;
    logic [1:0]  code;
    logic        wok, low, en_d_reg;
    always_comb begin
        wok = avs_write && !avs_waitrequest;
        ca_next = (wok && avs_address == 8'h74) ? avs_writedata[7:0] : ca_reg;
        cb_next = (wok && avs_address == 8'h75) ? {avs_writedata[7], avs_writedata[2:0]} : cb_reg;
        ad_next = ad_reg;
        if (wok && avs_address == 8'h78) ad_next[7:0] = avs_writedata[7:0];
        if (wok && avs_address == 8'h79) ad_next[15:8] = avs_writedata[7:0];
        // Strobe pins count only while they belonged to the interface
        low = en_d_reg && (!read_strobe_n || !write_strobe_n);
        cnt_next = low ? cnt_reg + 3'h1 : 3'h0;
        keep = (cb_reg[2:0] == 3'h7) ? 8'h00 : (8'hff >> cb_reg[2:0]);
        // Limit codes 00x leave only the upper sector
        code = (ca_reg[6:5] == 2'h0 || ad_reg >= {ca_reg[6:4], 13'h0000}) ? ca_reg[3:2]
                                                                          : ca_reg[1:0];
        len = (code == 2'h0) ? 3'h1 : ((code == 2'h1) ? 3'h2 : 3'h3);
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ca_reg <= 8'h00;
            cb_reg <= 4'h0;
            ad_reg <= 16'h0000;
            cnt_reg <= 3'h0;
            en_d_reg <= 1'b0;
        end else begin
            en_d_reg <= ext_mem_active;
            ca_reg <= ca_next;
            cb_reg <= cb_next;
            ad_reg <= ad_next;
            cnt_reg <= cnt_next;
        end
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);
    a_port_restore: assert property (!$past(reset) && !$past(ext_mem_active) |->
        high_address_lines_oe == $past(port_c_dir) && strobe_pins_oe == $past(port_g_dir))
        else $error("pins not returned to port settings");
    a_pin_takeover: assert property (!$past(reset) && $past(ext_mem_active) |->
        strobe_pins_oe == 3'h7 && high_address_lines_oe == ($past(keep) | ($past(port_c_dir)
        & ~$past(keep)))) else $error("pin takeover wrong");
    a_keeper_hold: assert property (!$past(reset) && $past(cb_reg[3]) |->
        mux_addr_data_lines_oe == 8'hff) else $error("keeper not holding lines");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest) else $error("bus answer late");
    a_reserved_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'h75
        |-> avs_readdata[6:3] == 4'h0) else $error("reserved bits not zero");
    a_latch_pulse: assert property (en_d_reg && addr_latch_strobe |=> !en_d_reg
        || (!addr_latch_strobe && !(read_strobe_n && write_strobe_n)))
        else $error("latch pulse or strobe order wrong");
    a_latch_addr: assert property (en_d_reg && addr_latch_strobe |->
        mux_addr_data_lines_out == ad_reg[7:0]
        && (high_address_lines_out & keep) == (ad_reg[15:8] & keep)) else $error("bad address");
    a_strobe_len: assert property (en_d_reg && !low && $past(low) |-> cnt_reg == len)
        else $error("strobe length wrong");
endmodule // xmem_ctrl_checker

bind xmem_ctrl xmem_ctrl_checker chk_u (.clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .port_a_dir, .port_c_dir, .port_g_dir,
    .mux_addr_data_lines_out, .mux_addr_data_lines_oe, .high_address_lines_out,
    .high_address_lines_oe, .addr_latch_strobe, .write_strobe_n, .read_strobe_n,
    .strobe_pins_oe, .ext_mem_active);
`default_nettype wire

//--- tb/xmem_sram.sv
// Behavioural byte-wide memory on the multiplexed address/data bus
`timescale 1ns/1ns
`default_nettype none
module xmem_sram (
    input  wire logic [7:0] mux_addr_data_lines_out,
    input  wire logic [7:0] mux_addr_data_lines_oe,
    input  wire logic [7:0] high_address_lines_out,
    input  wire logic       clk,
    input  wire logic       addr_latch_strobe,
    input  wire logic       write_strobe_n,
    input  wire logic       read_strobe_n,
    output logic [7:0]      mux_addr_data_lines_in
);
    logic [7:0]  mem [0:65535];
    logic [15:0] addr = 16'h0000;
    logic [7:0]  last = 8'h00;
    logic [1:0]  hold = 2'h0;
    logic        drv;
    // Data is held two cycles past the read strobe, then the released lines wander
    assign drv = !read_strobe_n || hold != 2'h0;
    assign mux_addr_data_lines_in = (mux_addr_data_lines_oe & mux_addr_data_lines_out)
        | (~mux_addr_data_lines_oe & (drv ? mem[addr] : ~last));
    always @(posedge clk) begin
        last <= mux_addr_data_lines_in;
        hold <= !read_strobe_n ? 2'h2 : ((hold != 2'h0) ? hold - 2'h1 : 2'h0);
        if (addr_latch_strobe) addr <= {high_address_lines_out, mux_addr_data_lines_out};
        if (!write_strobe_n) mem[addr] <= mux_addr_data_lines_out;
    end
endmodule // xmem_sram
`default_nettype wire

//--- tb/xmem_ctrl_tb.sv
// Randomised self-checking bench for the external memory interface
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module xmem_ctrl_tb;
    logic        clk, reset, avs_read, avs_write, avs_waitrequest, addr_latch_strobe;
    logic        write_strobe_n, read_strobe_n, ext_mem_active;
    logic [7:0]  avs_address, port_a_out, port_a_dir, port_c_out, port_c_dir;
    logic [7:0]  mux_addr_data_lines_in, mux_addr_data_lines_out, mux_addr_data_lines_oe;
    logic [7:0]  high_address_lines_out, high_address_lines_oe;
    logic [2:0]  port_g_out, port_g_dir, strobe_pins_oe;
    logic [31:0] avs_writedata, avs_readdata, rv, st, r;
    logic [15:0] a;
    integer      seed;
    int          n_errors = 0;
    int          num_checks = 0;
    xmem_ctrl dut_u (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .port_a_out, .port_a_dir, .port_c_out, .port_c_dir,
        .port_g_out, .port_g_dir, .mux_addr_data_lines_in, .mux_addr_data_lines_out,
        .mux_addr_data_lines_oe, .high_address_lines_out, .high_address_lines_oe,
        .addr_latch_strobe, .write_strobe_n, .read_strobe_n, .strobe_pins_oe, .ext_mem_active);
    xmem_sram mem_u (.clk, .mux_addr_data_lines_out, .mux_addr_data_lines_oe,
        .high_address_lines_out, .addr_latch_strobe, .write_strobe_n, .read_strobe_n,
        .mux_addr_data_lines_in);
    task automatic final_report();
        if (n_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic stall();
        n_errors++;
        $display("Error at %0t: wait ran out", $time);
        final_report();
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= ad;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // Request stands until the rising edge that samples waitrequest low
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) stall();
        rv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, 8'h76, 32'h0);
            st = rv;
            bus(1'b0, 8'h77, 32'h0);
            n++;
        end while ((st[2:0] !== 3'h0 || rv[0] !== 1'b0) && n < 30);
        if (st[2:0] !== 3'h0 || rv[0] !== 1'b0) stall();
    endtask
    function automatic logic [7:0] kept(input logic [2:0] k);
        return (k == 3'h7) ? 8'h00 : (8'hff >> k);
    endfunction
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        seed = 32'hec8b7f09;
        {reset, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 42'h0};
        {port_a_out, port_a_dir, port_c_out, port_c_dir, port_g_out, port_g_dir} = 38'h0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, 8'h74, 32'h0);
        `CHK(rv, 32'h0)
        bus(1'b0, 8'h75, 32'h0);
        `CHK(rv, 32'h0)
        bus(1'b0, 8'h10, 32'h0);
        `CHK(rv, 32'h0)
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            a = r[31:16];
            // Corner addresses sit on and just below the sector boundary for limit codes 010 to 111
            if (i[3]) a = {i[2:0], 13'h0000} - {15'h0, i[4]};
            if (a < 16'h2200) a = a | 16'h4000;
            {port_a_out, port_a_dir, port_c_out, port_c_dir} <= r;
            {port_g_out, port_g_dir} <= r[5:0];
            bus(1'b1, 8'h74, {24'h0, 1'b1, i[2:0], i[4:3], r[1:0]});
            bus(1'b1, 8'h78, {24'h0, a[7:0]});
            bus(1'b1, 8'h79, {24'h0, a[15:8]});
            bus(1'b1, 8'h7a, {24'h0, r[23:16]});
            bus(1'b1, 8'h77, 32'h2);
            idle();
            bus(1'b1, 8'h77, 32'h1);
            idle();
            bus(1'b0, 8'h7b, 32'h0);
            `CHK(rv, {24'h0, r[23:16]})
        end
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, 8'h74, 32'h80);
            bus(1'b1, 8'h75, {24'h0, k[0], 4'hf, k[2:0]});
            bus(1'b0, 8'h75, 32'h0);
            `CHK(rv, {24'h0, k[0], 4'h0, k[2:0]})
            @(negedge clk);
            `CHK(high_address_lines_oe, kept(k[2:0]) | (port_c_dir & ~kept(k[2:0])))
            bus(1'b1, 8'h74, 32'h0);
            bus(1'b0, 8'h74, 32'h0);
            @(negedge clk);
            `CHK(high_address_lines_oe, port_c_dir)
            `CHK(mux_addr_data_lines_oe, k[0] ? 8'hff : port_a_dir)
        end
        final_report();
    end
endmodule // xmem_ctrl_tb
`default_nettype wire
